// ### src/tsf_consts.vh
// Constants for the transmit scheduler and cell FIFO register bank.
// Assumes a 16-bit processor port with word addresses as printed.
// How it works
// - Ratio bit 3 set assembles cells one frame at a time, else four.
// - Control structure address is base bits 20:16 plus entry bits 15:4.
// - FIFO base field gives address bits 20:9, lower bits zero.
// - Every non-CBR cell slot owns a 64-byte buffer.
// - Size field 00/01/10/11 gives 16/32/64/128 cells.
// - Write pointer names the slot being filled; that slot is not valid.
// - Read-only read pointer names the slot being sent, valid until sent.
// - Control structure base bits 15:5 read as zero.
// - Write pointer moved onto read pointer with written bit 7 clear sets sticky overrun; write one clears.
`ifndef TSF_CONSTS_VH
`define TSF_CONSTS_VH
`define TSF_OFF_RATIO_A 16'h2014
`define TSF_OFF_RATIO_B 16'h2024
`define TSF_OFF_RATIO_C 16'h2034
`define TSF_OFF_CS_BASE 16'h2040
`define TSF_OFF_FF_BASE 16'h2050
`define TSF_OFF_FF_WP 16'h2052
`define TSF_OFF_FF_RP 16'h2054
`define TSF_OFF_STATUS 16'h2002
`define TSF_RESET_VAL 16'h0000
`define TSF_SINGLE_BIT 3
`define TSF_INIT_HI 7
`define TSF_INIT_LO 6
`define TSF_OVR_BIT 5
`define TSF_CELL_BYTES_LOG2 6
`endif

// ### src/tsf_skid.v
// Two-entry buffer for cell slot addresses.
// Assumes both sides on clk; output data from flip-flops.
`timescale 1ns/1ps
module tsf_skid (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [20:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [20:0] out_data
);
  reg [20:0] mem_q [0:1];
  reg wr_q;
  reg rd_q;
  reg [1:0] cnt_q;
  wire push;
  wire pop;
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge clk) begin
    if (rst) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
      mem_q[0] <= 21'h000000;
      mem_q[1] <= 21'h000000;
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q <= ~wr_q;
      end
      if (pop)
        rd_q <= ~rd_q;
      if (push && !pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop && !push)
        cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule // tsf_skid

// ### src/tsf_regs.v
// Transmit scheduler options and cell FIFO registers, processor port slave.
// Assumes a synchronous 16-bit word port on clk and a segmenter on the same clock.
`timescale 1ns/1ps
`include "tsf_consts.vh"
module tsf_regs (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Processor port
  input wire cpu_cs,
  input wire cpu_we,
  input wire [15:0] cpu_addr,
  input wire [15:0] cpu_wdata,
  output reg [15:0] cpu_rdata,
  // Scheduler state and FIFO enable from the control register
  input wire [2:0] sched_enabled,
  input wire cell_fifo_enable,
  // Control structure fetch
  input wire [1:0] cs_sched_sel,
  input wire [11:0] cs_entry,
  output reg [20:0] cs_addr,
  // Assembly options per scheduler
  output wire [2:0] single_frame,
  output wire [8:0] turn_ratio,
  output wire [5:0] packet_adapt_init_field,
  // Cell slot stream to the segmenter
  output wire cell_valid,
  input wire cell_ready,
  output wire [20:0] cell_addr,
  input wire cell_sent,
  // Status
  output wire cell_fifo_overrun_flag
);
  reg [5:0] ratio_q [0:2];
  reg [1:0] init_q [0:2];
  reg [4:0] ctrl_struct_base_field_q;
  reg [11:0] cell_fifo_base_field_q;
  reg [1:0] cell_fifo_size_field_q;
  reg [7:0] cell_fifo_write_ptr_q;
  reg [6:0] cell_fifo_read_ptr_q;
  reg [6:0] issue_ptr_q;
  reg overrun_q;
  wire wr;
  wire [6:0] last_slot;
  wire slot_avail;
  wire push;
  wire in_ready;
  integer i;

  // Slot address: base bits 20:9 plus slot times 64 bytes
  function [20:0] slot_addr;
    input [11:0] base;
    input [6:0] slot;
    begin
      slot_addr = {base, 9'h000} + ({14'h0, slot} << `TSF_CELL_BYTES_LOG2);
    end
  endfunction

  // Highest slot number for the size code
  function [6:0] cap_last;
    input [1:0] sz;
    begin
      case (sz)
        2'h0: cap_last = 7'h0f;
        2'h1: cap_last = 7'h1f;
        2'h2: cap_last = 7'h3f;
        default: cap_last = 7'h7f;
      endcase
    end
  endfunction

  assign wr = cpu_cs && cpu_we;
  assign last_slot = cap_last(cell_fifo_size_field_q);
  assign cell_fifo_overrun_flag = overrun_q;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : opt
      assign single_frame[g] = ratio_q[g][`TSF_SINGLE_BIT];
      assign turn_ratio[3*g+2:3*g] = ratio_q[g][2:0];
      assign packet_adapt_init_field[2*g+1:2*g] = init_q[g];
    end
  endgenerate

  // Control structure address
  always @(posedge clk) begin
    if (rst)
      cs_addr <= 21'h000000;
    else
      cs_addr <= {ctrl_struct_base_field_q, cs_entry, 4'h0};
  end

  // Slots between the issue pointer and the write pointer are ready to send
  assign slot_avail = cell_fifo_enable && (issue_ptr_q != cell_fifo_write_ptr_q[6:0]);
  assign push = slot_avail && in_ready;

  tsf_skid u_skid (
    .clk(clk),
    .rst(rst),
    .in_valid(slot_avail),
    .in_ready(in_ready),
    .in_data(slot_addr(cell_fifo_base_field_q, issue_ptr_q)),
    .out_valid(cell_valid),
    .out_ready(cell_ready),
    .out_data(cell_addr)
  );

  // Register writes, pointers and overrun flag
  always @(posedge clk) begin
    if (rst) begin
      for (i = 0; i < 3; i = i + 1) begin
        ratio_q[i] <= 6'h00;
        init_q[i] <= 2'h0;
      end
      ctrl_struct_base_field_q <= 5'h00;
      cell_fifo_base_field_q <= 12'h000;
      cell_fifo_size_field_q <= 2'h0;
      cell_fifo_write_ptr_q <= 8'h00;
      cell_fifo_read_ptr_q <= 7'h00;
      issue_ptr_q <= 7'h00;
      overrun_q <= 1'b0;
    end else begin
      if (wr) begin
        case (cpu_addr)
          `TSF_OFF_RATIO_A: begin
            ratio_q[0] <= cpu_wdata[5:0];
            init_q[0] <= cpu_wdata[`TSF_INIT_HI:`TSF_INIT_LO];
          end
          `TSF_OFF_RATIO_B: begin
            ratio_q[1] <= cpu_wdata[5:0];
            init_q[1] <= cpu_wdata[`TSF_INIT_HI:`TSF_INIT_LO];
          end
          `TSF_OFF_RATIO_C: begin
            ratio_q[2] <= cpu_wdata[5:0];
            init_q[2] <= cpu_wdata[`TSF_INIT_HI:`TSF_INIT_LO];
          end
          `TSF_OFF_CS_BASE: ctrl_struct_base_field_q <= cpu_wdata[4:0];
          `TSF_OFF_FF_BASE: begin
            cell_fifo_base_field_q <= cpu_wdata[11:0];
            cell_fifo_size_field_q <= cpu_wdata[13:12];
          end
          `TSF_OFF_FF_WP: cell_fifo_write_ptr_q <= cpu_wdata[7:0];
          default: ;
        endcase
      end
      // Skid buffer takes a slot; read pointer follows each finished cell
      if (!cell_fifo_enable)
        issue_ptr_q <= cell_fifo_read_ptr_q;
      else if (push)
        issue_ptr_q <= (issue_ptr_q == last_slot) ? 7'h00 : issue_ptr_q + 7'h01;
      if (cell_sent)
        cell_fifo_read_ptr_q <= (cell_fifo_read_ptr_q == last_slot) ?
          7'h00 : cell_fifo_read_ptr_q + 7'h01;
      // Set wins over clear
      if (wr && cpu_addr == `TSF_OFF_FF_WP &&
          cpu_wdata[7:0] != cell_fifo_write_ptr_q &&
          cpu_wdata[6:0] == cell_fifo_read_ptr_q && cpu_wdata[7] == 1'b0)
        overrun_q <= 1'b1;
      else if (wr && cpu_addr == `TSF_OFF_STATUS && cpu_wdata[`TSF_OVR_BIT])
        overrun_q <= 1'b0;
    end
  end

  // Read data; init field write-only, reserved bits zero
  always @(posedge clk) begin
    if (rst)
      cpu_rdata <= `TSF_RESET_VAL;
    else if (cpu_cs && !cpu_we) begin
      case (cpu_addr)
        `TSF_OFF_RATIO_A: cpu_rdata <= {10'h000, ratio_q[0]};
        `TSF_OFF_RATIO_B: cpu_rdata <= {10'h000, ratio_q[1]};
        `TSF_OFF_RATIO_C: cpu_rdata <= {10'h000, ratio_q[2]};
        `TSF_OFF_CS_BASE: cpu_rdata <= {11'h000, ctrl_struct_base_field_q};
        `TSF_OFF_FF_BASE: cpu_rdata <= {2'h0, cell_fifo_size_field_q, cell_fifo_base_field_q};
        `TSF_OFF_FF_WP: cpu_rdata <= {8'h00, cell_fifo_write_ptr_q};
        `TSF_OFF_FF_RP: cpu_rdata <= {9'h000, cell_fifo_read_ptr_q};
        `TSF_OFF_STATUS: cpu_rdata <= {10'h000, overrun_q, 5'h00};
        default: cpu_rdata <= 16'h0000;
      endcase
    end
  end
endmodule // tsf_regs

// ### test/tsf_regs_sva.sv
// Port checker for the scheduler and cell FIFO register bank.
// Assumes a bind to tsf_regs on one clock.
`timescale 1ns/1ps
module tsf_regs_chk (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Processor port
  input wire cpu_cs,
  input wire cpu_we,
  input wire [15:0] cpu_addr,
  input wire [15:0] cpu_wdata,
  input wire [15:0] cpu_rdata,
  // Scheduler state and FIFO enable
  input wire [2:0] sched_enabled,
  input wire cell_fifo_enable,
  // Control structure fetch
  input wire [1:0] cs_sched_sel,
  input wire [11:0] cs_entry,
  input wire [20:0] cs_addr,
  // Assembly options
  input wire [2:0] single_frame,
  input wire [8:0] turn_ratio,
  input wire [5:0] packet_adapt_init_field,
  // Cell slot stream
  input wire cell_valid,
  input wire cell_ready,
  input wire [20:0] cell_addr,
  input wire cell_sent,
  // Status
  input wire cell_fifo_overrun_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  reg [15:0] wd_q;
  wire rd = cpu_cs && !cpu_we;
  wire wr = cpu_cs && cpu_we;
  always @(posedge clk) wd_q <= cpu_wdata;
  property p_cs; !$past(rst) |-> cs_addr[15:0] == {$past(cs_entry), 4'h0}; endproperty
  a_cs: assert property (p_cs) else $error("cs_addr wrong");
  property p_al; cell_valid |-> cell_addr[5:0] == 6'h00; endproperty
  a_al: assert property (p_al) else $error("cell_addr unaligned");
  property p_hd; cell_valid && !cell_ready |=> cell_valid && $stable(cell_addr); endproperty
  a_hd: assert property (p_hd) else $error("cell dropped");
  property p_csr; rd && cpu_addr == 16'h2040 |=> cpu_rdata[15:5] == 11'h000; endproperty
  a_csr: assert property (p_csr) else $error("base reserved set");
  property p_rp; rd && cpu_addr == 16'h2054 |=> cpu_rdata[15:7] == 9'h000; endproperty
  a_rp: assert property (p_rp) else $error("read ptr reserved set");
  property p_ov;
    cell_fifo_overrun_flag && !(wr && cpu_addr == 16'h2002 && cpu_wdata[5])
      |=> cell_fifo_overrun_flag;
  endproperty
  a_ov: assert property (p_ov) else $error("overrun lost");
  property p_sf;
    wr && cpu_addr == 16'h2014 |=> single_frame[0] == wd_q[3] && turn_ratio[2:0] == wd_q[2:0];
  endproperty
  a_sf: assert property (p_sf) else $error("ratio A wrong");
  property p_in; wr && cpu_addr == 16'h2034 |=> packet_adapt_init_field[5:4] == wd_q[7:6];
  endproperty
  a_in: assert property (p_in) else $error("init C wrong");
  c_take: cover property (cell_valid && cell_ready);
  c_ov: cover property ($rose(cell_fifo_overrun_flag));
  c_clr: cover property (wr && cpu_addr == 16'h2002);
endmodule // tsf_regs_chk
bind tsf_regs tsf_regs_chk u_tsf_regs_chk (.*);

// ### test/tsf_seg_model.sv
// Segmenter stand-in: takes cell slots, pulses sent a cycle later.
// Assumes the bench drives stall; same clock as the bank.
`timescale 1ns/1ps
module tsf_seg_model (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Bench control
  input wire stall,
  // Cell slot stream from the bank
  input wire cell_valid,
  input wire [20:0] cell_addr,
  output wire cell_ready,
  output reg cell_sent,
  // Observation
  output reg [20:0] last_addr,
  output reg [7:0] sent_cnt
);
  assign cell_ready = !stall;
  always @(posedge clk) begin
    if (rst) begin
      cell_sent <= 1'b0;
      last_addr <= 21'h000000;
      sent_cnt <= 8'h00;
    end else begin
      cell_sent <= cell_valid && cell_ready;
      if (cell_valid && cell_ready) begin
        last_addr <= cell_addr;
        sent_cnt <= sent_cnt + 8'h01;
      end
    end
  end
endmodule // tsf_seg_model

// ### test/tx_sched_fifo_regs_bench.sv
// Self-checking bench for the scheduler and cell FIFO register bank.
// Assumes tsf_regs, tsf_seg_model and the bound checker.
`timescale 1ns/1ps
module tx_sched_fifo_regs_bench;
  reg clk = 1'b0, rst = 1'b1, cs = 1'b0, we = 1'b0, fen = 1'b0, stall = 1'b1;
  reg [15:0] addr = 16'h0000, wd = 16'h0000, d;
  reg [11:0] ent = 12'h000;
  wire [15:0] rdata;
  wire [20:0] csa, caddr, last;
  wire [2:0] sf;
  wire [8:0] tr;
  wire [5:0] pai;
  wire [7:0] cnt;
  wire cv, cr, sent, ovr;
  integer error_cnt = 0, tests_run = 0, i;
  tsf_regs u_tsf_regs (.clk(clk), .rst(rst), .cpu_cs(cs), .cpu_we(we), .cpu_addr(addr),
    .cpu_wdata(wd), .cpu_rdata(rdata), .sched_enabled(3'h0), .cell_fifo_enable(fen),
    .cs_sched_sel(2'h0), .cs_entry(ent), .cs_addr(csa), .single_frame(sf), .turn_ratio(tr),
    .packet_adapt_init_field(pai), .cell_valid(cv), .cell_ready(cr), .cell_addr(caddr),
    .cell_sent(sent), .cell_fifo_overrun_flag(ovr));
  tsf_seg_model u_tsf_seg_model (.clk(clk), .rst(rst), .stall(stall), .cell_valid(cv),
    .cell_addr(caddr), .cell_ready(cr), .cell_sent(sent), .last_addr(last), .sent_cnt(cnt));
  initial forever #10 clk = ~clk;
  task step; begin @(posedge clk); #1; end endtask
  task chk(input [95:0] n, input [20:0] e, g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("unexpected %0s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task wr(input [15:0] a, v); begin cs = 1; we = 1; addr = a; wd = v; step; cs = 0; step; end
  endtask
  task rd(input [15:0] a); begin cs = 1; we = 0; addr = a; step; cs = 0; step; d = rdata; end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task t_reset;
    reg [143:0] m;
    begin
      m = {16'h2014, 16'h2024, 16'h2034, 16'h2040, 16'h2050, 16'h2052, 16'h2054,
        16'h2002, 16'h2060};
      for (i = 0; i < 9; i = i + 1) begin
        rd(m[i*16 +: 16]);
        chk("reset", 21'h0, {5'h0, d});
      end
    end
  endtask
  task t_ratio;
    begin
      wr(16'h2014, 16'h004f);
      wr(16'h2024, 16'h0083);
      wr(16'h2034, 16'h00c1);
      chk("single", 21'h1, {18'h0, sf});
      chk("ratio", 21'h05f, {12'h0, tr});
      chk("init", 21'h39, {15'h0, pai});
      rd(16'h2014);
      chk("ratio_rd", 21'h00f, {5'h0, d});
    end
  endtask
  task t_base;
    begin
      wr(16'h2040, 16'hffff);
      rd(16'h2040);
      chk("cs_base", 21'h1f, {5'h0, d});
      ent = 12'habc;
      step;
      step;
      chk("cs_addr", 21'h1fabc0, csa);
    end
  endtask
  task t_fifo;
    begin
      wr(16'h2050, 16'h0123);
      rd(16'h2050);
      chk("ff_base", 21'h123, {5'h0, d});
      fen = 1;
      wr(16'h2052, 16'h0002);
      for (i = 0; i < 20 && cv !== 1'b1; i = i + 1) step;
      chk("cv_wait", 21'h1, {20'h0, cv});
      if (cv !== 1'b1) tally_and_finish;
      chk("cell0", 21'h024600, caddr);
      stall = 0;
      for (i = 0; i < 50 && cnt !== 8'h02; i = i + 1) step;
      repeat (4) step;
      chk("cell1", 21'h024640, last);
      chk("sent", 21'h2, {13'h0, cnt});
      if (cnt !== 8'h02) tally_and_finish;
      rd(16'h2054);
      chk("rd_ptr", 21'h2, {5'h0, d});
      fen = 0;
      wr(16'h2052, 16'h0003);
      wr(16'h2052, 16'h0002);
      chk("overrun", 21'h1, {20'h0, ovr});
      rd(16'h2002);
      chk("status", 21'h20, {5'h0, d});
      wr(16'h2002, 16'h0020);
      chk("ovr_clr", 21'h0, {20'h0, ovr});
    end
  endtask
  // Run the FIFO from the read pointer up to a new write pointer; all runs but the third cross the wrap
  task t_run(input [15:0] cfg, input [7:0] wp, input [7:0] c, input [6:0] rp_e,
    input [20:0] last_e);
    begin
      fen = 0;
      wr(16'h2050, cfg);
      wr(16'h2052, {8'h00, wp});
      fen = 1;
      for (i = 0; i < 300 && cnt !== c; i = i + 1) step;
      repeat (4) step;
      chk("run_cnt", {13'h0, c}, {13'h0, cnt});
      if (cnt !== c) tally_and_finish;
      chk("run_last", last_e, last);
      chk("run_ovr", 21'h0, {20'h0, ovr});
      fen = 0;
      rd(16'h2054);
      chk("run_rp", {14'h0, rp_e}, {5'h0, d});
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst = 0;
    step;
    t_reset;
    t_ratio;
    t_base;
    t_fifo;
    t_run(16'h0123, 8'h01, 8'h11, 7'h01, 21'h024600);
    t_run(16'h3120, 8'h00, 8'h90, 7'h00, 21'h025fc0);
    t_run(16'h1123, 8'h1f, 8'haf, 7'h1f, 21'h024d80);
    t_run(16'h2123, 8'h1e, 8'hee, 7'h1e, 21'h024d40);
    tally_and_finish;
  end
endmodule // tx_sched_fifo_regs_bench
